/* hdl/iox_defs.svh */
`ifndef IOX_DEFS_SVH
`define IOX_DEFS_SVH

// target address: fixed upper five bits, straps fill the low two
`define IOX_ADDR_BASE   5'h1D
`define IOX_RW_READ     1'h1
`define IOX_ACK_LEVEL   1'h0

// command byte: bits 2:1 pick the register group, bit 0 the port
`define IOX_GRP_IN      2'h0
`define IOX_GRP_OUT     2'h1
`define IOX_GRP_POL     2'h2
`define IOX_GRP_DIR     2'h3
`define IOX_PTR_RST     3'h0

// register reset values
`define IOX_OUT_RST     8'hFF
`define IOX_POL_RST     8'h00
`define IOX_DIR_RST     8'hFF
`define IOX_IN_RST      8'h00

// bit counter value of the eighth bit of a byte
`define IOX_BIT_LAST    3'h7
`define IOX_BIT_FIRST   3'h1
`define IOX_BIT_ZERO    3'h0

`endif

/* hdl/iox_pkg.sv */
`default_nettype none

package iox_pkg;

    typedef enum logic [2:0] {
        IOX_ST_IDLE  = 3'b000,
        IOX_ST_ADDR  = 3'b001,
        IOX_ST_ACK_A = 3'b010,
        IOX_ST_RX    = 3'b011,
        IOX_ST_ACK_W = 3'b100,
        IOX_ST_TX    = 3'b101,
        IOX_ST_ACK_R = 3'b110
    } iox_link_state_t;

endpackage

`default_nettype wire

/* hdl/iox_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module iox_sync
    import iox_pkg::*;
#(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end

endmodule

`default_nettype wire

/* hdl/iox_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iox_defs.svh"

module iox_port
    import iox_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       dev_rst,
    // pin side
    input  wire logic [7:0] pin_level,
    output logic      [7:0] pin_drv,
    output logic      [7:0] pin_oe,
    output logic      [7:0] pullup_transistor,
    output logic      [7:0] pulldown_transistor,
    // register access
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_grp,
    input  wire logic [7:0] wr_byte,
    input  wire logic       rd_clr,
    output logic      [7:0] in_reg,
    output logic      [7:0] out_reg,
    output logic      [7:0] pol_reg,
    output logic      [7:0] dir_reg,
    // change alert
    output logic            alert
);

    logic [7:0] ref_level;
    logic       armed;

    wire logic [7:0] next_in  = pin_level ^ pol_reg;                 // [R5] [R17]
    wire logic [7:0] changed  = (in_reg ^ ref_level) & dir_reg;      // [R8]
    wire logic       wr_out   = wr_en && (wr_grp == `IOX_GRP_OUT);
    wire logic       wr_pol   = wr_en && (wr_grp == `IOX_GRP_POL);
    wire logic       wr_dir   = wr_en && (wr_grp == `IOX_GRP_DIR);   // [R3]
    wire logic       take_ref = !armed || rd_clr;                    // [R15]

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            out_reg   <= `IOX_OUT_RST;                               // [R16]
            pol_reg   <= `IOX_POL_RST;                               // [R16]
            dir_reg   <= `IOX_DIR_RST;                               // [R2] [R16]
            in_reg    <= `IOX_IN_RST;
            ref_level <= `IOX_IN_RST;
            armed     <= 1'b0;
            alert     <= 1'b0;
        end else begin
            in_reg <= next_in;                                       // [R4]
            if (wr_out) out_reg <= wr_byte;                          // [R4]
            if (wr_pol) pol_reg <= wr_byte;
            if (wr_dir) dir_reg <= wr_byte;
            if (take_ref) ref_level <= next_in;
            armed <= 1'b1;
            alert <= |changed;                                       // [R8] [R15]
        end
    end

    // a set direction bit means input: both transistors off
    assign pin_drv             = out_reg;
    assign pin_oe              = ~dir_reg;                           // [R10]
    assign pullup_transistor   = ~dir_reg & out_reg;                 // [R11]
    assign pulldown_transistor = ~dir_reg & ~out_reg;                // [R11]

endmodule

`default_nettype wire

/* hdl/iox_expander.sv */
// Operation
// [R1] two 8-bit ports, four registers each
// [R2] every pin is an input after reset
// [R3] direction bit written selects pin direction
// [R4] input and output registers hold pin values
// [R5] polarity bit inverts reported input level
// [R6] every register can be read back
// [R7] reset pin low resets registers and bus
// [R8] alert low while input differs from held
// [R9] two straps set the target address
// [R10] input pin: both transistors off
// [R11] output pin: transistor chosen by output bit
// [R12] seven-bit address 74h-77h, read bit one
// [R13] command low bits pick one of eight
// [R14] reads keep last selected register pair
// [R15] alert releases on return or port read
// [R16] reset values: outputs ones, polarity zeros
// [R17] input registers ignore writes, follow pins
`timescale 1ns/1ps
`default_nettype none
`include "iox_defs.svh"

module iox_expander
    import iox_pkg::*;
(
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        ext_rst_n,
    // serial link
    input  wire logic        scl_clk,
    input  wire logic        sda_pin,
    output logic             sda_drv,
    output logic             sda_oe,
    // address straps
    input  wire logic        addr_strap_low,
    input  wire logic        addr_strap_high,
    // port pins
    input  wire logic [15:0] port_level,
    output logic      [15:0] port_drv,
    output logic      [15:0] port_oe,
    output logic      [15:0] pullup_transistor,
    output logic      [15:0] pulldown_transistor,
    // change alert, open drain
    output logic             alert_drv,
    output logic             alert_oe
);

    // ------------------------------------------------------------
    // system domain: reset, straps, pin synchronisers
    // ------------------------------------------------------------
    logic        rst_n_s;
    logic        link_rst;
    logic [1:0]  strap_s;
    logic [1:0]  strap_q;
    logic        strap_done;
    logic [15:0] level_s;

    iox_sync #(.W(1)) u_rst_sync (
        .clk (clk_sys),
        .d   (ext_rst_n),
        .q   (rst_n_s)
    );

    iox_sync #(.W(2)) u_strap_sync (
        .clk (clk_sys),
        .d   ({addr_strap_high, addr_strap_low}),
        .q   (strap_s)
    );

    iox_sync #(.W(16)) u_pin_sync (
        .clk (clk_sys),
        .d   (port_level),
        .q   (level_s)
    );

    // the synchronised reset pin acts exactly like the system reset
    wire logic dev_rst = sys_rst || !rst_n_s;                        // [R7]

    // link-side reset, registered so it is glitch free
    always_ff @(posedge clk_sys) begin
        link_rst <= dev_rst;                                         // [R7]
    end

    // straps are caught once, on the first edge after release
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            strap_done <= 1'b0;
            strap_q    <= 2'h0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            strap_q    <= strap_s;                                   // [R9]
        end
    end

    // ------------------------------------------------------------
    // link to system crossings
    // ------------------------------------------------------------
    logic       wr_tog;
    logic [2:0] wr_sel;
    logic [7:0] wr_byte;
    logic [1:0] rd_tog;
    logic       wr_tog_s;
    logic       wr_tog_d;
    logic [1:0] rd_tog_s;
    logic [1:0] rd_tog_d;

    iox_sync #(.W(1)) u_wr_sync (
        .clk (clk_sys),
        .d   (wr_tog),
        .q   (wr_tog_s)
    );

    iox_sync #(.W(2)) u_rd_sync (
        .clk (clk_sys),
        .d   (rd_tog),
        .q   (rd_tog_s)
    );

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            wr_tog_d <= 1'b0;
            rd_tog_d <= 2'h0;
        end else begin
            wr_tog_d <= wr_tog_s;
            rd_tog_d <= rd_tog_s;
        end
    end

    // wr_sel and wr_byte are held by the link until the next byte
    wire logic       wr_pulse = wr_tog_s ^ wr_tog_d;
    wire logic [1:0] rd_pulse = rd_tog_s ^ rd_tog_d;
    wire logic [1:0] wr_grp   = wr_sel[2:1];
    wire logic       wr_ok    = wr_pulse && (wr_grp != `IOX_GRP_IN); // [R17]

    // ------------------------------------------------------------
    // the two ports
    // ------------------------------------------------------------
    logic [7:0] in_reg  [0:1];
    logic [7:0] out_reg [0:1];
    logic [7:0] pol_reg [0:1];
    logic [7:0] dir_reg [0:1];
    logic [1:0] port_alert;
    logic [7:0] reg_file [0:7];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            wire logic port_hit = (wr_sel[0] == p[0]);

            iox_port u_port (                                        // [R1]
                .clk_sys             (clk_sys),
                .dev_rst             (dev_rst),
                .pin_level           (level_s[8*p +: 8]),
                .pin_drv             (port_drv[8*p +: 8]),
                .pin_oe              (port_oe[8*p +: 8]),
                .pullup_transistor   (pullup_transistor[8*p +: 8]),
                .pulldown_transistor (pulldown_transistor[8*p +: 8]),
                .wr_en               (wr_ok && port_hit),
                .wr_grp              (wr_grp),
                .wr_byte             (wr_byte),
                .rd_clr              (rd_pulse[p]),
                .in_reg              (in_reg[p]),
                .out_reg             (out_reg[p]),
                .pol_reg             (pol_reg[p]),
                .dir_reg             (dir_reg[p]),
                .alert               (port_alert[p])
            );

            // register index is {group, port}
            assign reg_file[{`IOX_GRP_IN,  p[0]}] = in_reg[p];       // [R6]
            assign reg_file[{`IOX_GRP_OUT, p[0]}] = out_reg[p];      // [R6]
            assign reg_file[{`IOX_GRP_POL, p[0]}] = pol_reg[p];      // [R6]
            assign reg_file[{`IOX_GRP_DIR, p[0]}] = dir_reg[p];      // [R6]
        end
    endgenerate

    logic alert_q;

    always_ff @(posedge clk_sys) begin
        if (dev_rst) alert_q <= 1'b0;
        else alert_q <= |port_alert;                                 // [R8]
    end

    assign alert_drv = 1'b0;
    assign alert_oe  = alert_q;                                      // [R8]

    // ------------------------------------------------------------
    // link domain: start detection
    // ------------------------------------------------------------
    // a falling data line while the clock is high marks a start;
    // the flag is wiped right after the link has taken it
    logic start_pend;
    logic start_ack;

    wire logic start_clr = link_rst || start_ack;

    always_ff @(negedge sda_pin or posedge start_clr) begin
        if (start_clr) start_pend <= 1'b0;
        else start_pend <= scl_clk;
    end

    // ------------------------------------------------------------
    // link domain: target state machine
    // ------------------------------------------------------------
    iox_link_state_t state;
    logic [2:0]      bit_cnt;
    logic [6:0]      shreg;
    logic            cmd_phase;
    logic [2:0]      ptr;
    logic [7:0]      tx_byte;

    // straps are static once captured, so the link reads them directly
    wire logic [6:0] my_addr   = {`IOX_ADDR_BASE, strap_q};          // [R9] [R12]
    wire logic [7:0] byte_in   = {shreg, sda_pin};
    wire logic       byte_done = (bit_cnt == `IOX_BIT_LAST);
    wire logic       addr_hit  = (byte_in[7:1] == my_addr);          // [R12]
    wire logic       is_read   = (byte_in[0] == `IOX_RW_READ);       // [R12]
    wire logic       m_ack     = (sda_pin == `IOX_ACK_LEVEL);
    // pointer stays on its pair; only bit 0 alternates
    wire logic [2:0] ptr_pair  = {ptr[2:1], ~ptr[0]};                // [R14]
    wire logic       ptr_in    = (ptr[2:1] == `IOX_GRP_IN);
    wire logic [7:0] tx_next   = reg_file[ptr];                      // [R6]

    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) start_ack <= 1'b0;
        else start_ack <= start_pend;
    end

    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            state     <= IOX_ST_IDLE;                                // [R7]
            bit_cnt   <= `IOX_BIT_ZERO;
            shreg     <= 7'h00;
            cmd_phase <= 1'b0;
            ptr       <= `IOX_PTR_RST;
            tx_byte   <= 8'h00;
            wr_tog    <= 1'b0;
            wr_sel    <= 3'h0;
            wr_byte   <= 8'h00;
            rd_tog    <= 2'h0;
        end else if (start_pend) begin
            // first address bit sampled on this edge
            state   <= IOX_ST_ADDR;
            shreg   <= {6'h00, sda_pin};
            bit_cnt <= `IOX_BIT_FIRST;
        end else begin
            case (state)
                IOX_ST_ADDR: begin
                    shreg   <= byte_in[6:0];
                    bit_cnt <= bit_cnt + 3'h1;
                    if (byte_done) begin
                        state     <= addr_hit ? IOX_ST_ACK_A : IOX_ST_IDLE;
                        cmd_phase <= !is_read;
                        shreg[0]  <= is_read;
                    end
                end
                IOX_ST_ACK_A: begin
                    bit_cnt <= `IOX_BIT_ZERO;
                    if (shreg[0]) begin
                        // read: load the byte; an input-register read clears that port's alert
                        state   <= IOX_ST_TX;
                        tx_byte <= tx_next;
                        if (ptr_in) rd_tog[ptr[0]] <= ~rd_tog[ptr[0]]; // [R15]
                    end else begin
                        state <= IOX_ST_RX;
                    end
                end
                IOX_ST_RX: begin
                    shreg   <= byte_in[6:0];
                    bit_cnt <= bit_cnt + 3'h1;
                    if (byte_done) begin
                        state     <= IOX_ST_ACK_W;
                        cmd_phase <= 1'b0;
                        if (cmd_phase) begin
                            ptr <= byte_in[2:0];                     // [R13]
                        end else begin
                            wr_sel  <= ptr;                          // [R3]
                            wr_byte <= byte_in;
                            wr_tog  <= ~wr_tog;
                            ptr     <= ptr_pair;                     // [R14]
                        end
                    end
                end
                IOX_ST_ACK_W: begin
                    state   <= IOX_ST_RX;
                    bit_cnt <= `IOX_BIT_ZERO;
                end
                IOX_ST_TX: begin
                    bit_cnt <= bit_cnt + 3'h1;
                    if (byte_done) begin
                        state <= IOX_ST_ACK_R;
                        ptr   <= ptr_pair;                           // [R14]
                    end
                end
                IOX_ST_ACK_R: begin
                    bit_cnt <= `IOX_BIT_ZERO;
                    if (m_ack) begin
                        state   <= IOX_ST_TX;
                        tx_byte <= tx_next;
                        if (ptr_in) rd_tog[ptr[0]] <= ~rd_tog[ptr[0]]; // [R15]
                    end else begin
                        state <= IOX_ST_IDLE;
                    end
                end
                default: begin
                    state   <= IOX_ST_IDLE;
                    bit_cnt <= `IOX_BIT_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // link domain: data line driver, changes while the clock is low
    // ------------------------------------------------------------
    wire logic ack_drive = (state == IOX_ST_ACK_A) || (state == IOX_ST_ACK_W);
    wire logic tx_low    = (state == IOX_ST_TX) && !tx_byte[~bit_cnt];
    wire logic next_oe   = ack_drive || tx_low;

    always_ff @(negedge scl_clk or posedge link_rst) begin
        if (link_rst) sda_oe <= 1'b0;
        else sda_oe <= next_oe;
    end

    assign sda_drv = 1'b0;

endmodule

`default_nettype wire

/* test/iox_expander_props.sv */
`timescale 1ns/1ps
`default_nettype none

module iox_expander_props (
    // clock and resets
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        ext_rst_n,
    // link
    input wire logic        scl_clk,
    input wire logic        sda_drv,
    // port pins
    input wire logic [15:0] port_level,
    input wire logic [15:0] port_drv,
    input wire logic [15:0] port_oe,
    input wire logic [15:0] pullup_transistor,
    input wire logic [15:0] pulldown_transistor,
    // alert
    input wire logic        alert_drv,
    input wire logic        alert_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // link idle, no reset pending and pins steady
    sequence s_quiet;
        (scl_clk && ext_rst_n && $stable(port_level)) [*8];
    endsequence

    chk_pullup_match: assert property (pullup_transistor == (port_oe & port_drv))
        else $error("pull-up enable differs from driven output bits");
    chk_pulldown_match: assert property (pulldown_transistor == (port_oe & ~port_drv))
        else $error("pull-down enable differs from driven output bits");
    chk_input_hiz: assert property (
        ((pullup_transistor | pulldown_transistor) & ~port_oe) == 16'h0000)
        else $error("transistor enabled on an input pin");
    chk_reset_inputs: assert property ($fell(sys_rst) |-> port_oe == 16'h0000)
        else $error("pin driven right after reset");
    chk_reset_outs: assert property ($fell(sys_rst) |-> port_drv == 16'hFFFF)
        else $error("output register not all ones after reset");
    chk_ext_reset: assert property (!ext_rst_n [*6] |-> port_oe == 16'h0000 && !alert_oe)
        else $error("reset pin did not return pins and alert to default");
    chk_open_drain: assert property (sda_drv == 1'h0 && alert_drv == 1'h0)
        else $error("open-drain output driven high");
    chk_alert_steady: assert property (s_quiet ##1 s_quiet |-> $stable(alert_oe))
        else $error("alert moved with pins and link idle");
endmodule

bind iox_expander iox_expander_props u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n), .scl_clk(scl_clk),
    .sda_drv(sda_drv), .port_level(port_level), .port_drv(port_drv), .port_oe(port_oe),
    .pullup_transistor(pullup_transistor), .pulldown_transistor(pulldown_transistor),
    .alert_drv(alert_drv), .alert_oe(alert_oe)
);

`default_nettype wire

/* test/iox_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module iox_ctl_model (
    // serial link; clock stands high between frames
    output logic      scl_clk,
    output logic      sda_pull,
    input  wire logic sda_pin
);
    initial begin
        scl_clk = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic put_bit(input logic b);
        #20 sda_pull = ~b;
        #20 scl_clk = 1'b1;
        #40 scl_clk = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #20 sda_pull = 1'b0;
        #20 scl_clk = 1'b1;
        b = sda_pin;
        #40 scl_clk = 1'b0;
    endtask
    // also a repeated start when the clock is low
    task automatic start();
        #20 sda_pull = 1'b0;
        #20 scl_clk = 1'b1;
        #20 sda_pull = 1'b1;
        #20 scl_clk = 1'b0;
    endtask
    task automatic stop();
        #20 sda_pull = 1'b1;
        #20 scl_clk = 1'b1;
        #20 sda_pull = 1'b0;
    endtask
    // msb first, ninth clock carries the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        get_bit(n);
        ack = ~n;
    endtask
    task automatic recv_byte(output logic [7:0] b, input logic more);
        for (int i = 7; i >= 0; i--) get_bit(b[i]);
        put_bit(~more);
    endtask
endmodule

`default_nettype wire

/* test/test_iox_expander.sv */
`timescale 1ns/1ps
`default_nettype none

module test_iox_expander;
    localparam logic [6:0] DEV = 7'h76;
    localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
    logic        clk_sys;
    logic        sys_rst;
    logic        ext_rst_n;
    logic [15:0] pin_ext;
    logic        ack;
    logic [7:0]  rd_a;
    logic [7:0]  rd_b;
    int          num_errors;
    int          n_checks;
    wire         scl_clk;
    wire         sda_pull;
    wire         sda_oe;
    wire         sda_pin;
    wire         alert_oe;
    wire  [15:0] port_drv;
    wire  [15:0] port_oe;
    wire  [15:0] pull_hi;
    wire  [15:0] pull_lo;
    wire  [15:0] port_level;

    // pull-up on data; driven pins show the driven level
    assign sda_pin = ~(sda_oe | sda_pull);
    assign port_level = (port_oe & port_drv) | (~port_oe & pin_ext);

    iox_expander u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n),
        .scl_clk(scl_clk), .sda_pin(sda_pin), .sda_drv(), .sda_oe(sda_oe),
        .addr_strap_low(1'b0), .addr_strap_high(1'b1), .port_level(port_level),
        .port_drv(port_drv), .port_oe(port_oe), .pullup_transistor(pull_hi),
        .pulldown_transistor(pull_lo), .alert_drv(), .alert_oe(alert_oe)
    );
    iox_ctl_model u_ctl (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_pin(sda_pin));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] idx, input logic [7:0] val);
        u_ctl.start();
        u_ctl.send_byte({DEV, 1'b0}, ack);
        u_ctl.send_byte({5'h00, idx}, ack);
        u_ctl.send_byte(val, ack);
        u_ctl.stop();
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic reg_rd(input logic [2:0] idx, input logic [7:0] exp);
        u_ctl.start();
        u_ctl.send_byte({DEV, 1'b0}, ack);
        u_ctl.send_byte({5'h00, idx}, ack);
        u_ctl.start();
        u_ctl.send_byte({DEV, 1'b1}, ack);
        u_ctl.recv_byte(rd_a, 1'b0);
        u_ctl.stop();
        check({8'h00, rd_a}, {8'h00, exp});
    endtask
    // read two bytes without a new command byte
    task automatic rd_pair(input logic [7:0] e0, input logic [7:0] e1);
        u_ctl.start();
        u_ctl.send_byte({DEV, 1'b1}, ack);
        u_ctl.recv_byte(rd_a, 1'b1);
        u_ctl.recv_byte(rd_b, 1'b0);
        u_ctl.stop();
        check({rd_a, rd_b}, {e0, e1});
    endtask
    task automatic alert_is(input logic e);
        repeat (8) @(negedge clk_sys);
        check({15'h0000, alert_oe}, {15'h0000, e});
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        wrap_up();
    end

    initial begin
        num_errors = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        ext_rst_n = 1'b1;
        pin_ext = 16'h3C5A;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(port_oe, 16'h0000);
        check(pull_hi | pull_lo, 16'h0000);
        for (int i = 2; i < 8; i++) reg_rd(3'(i), RST_TAB[i]);
        reg_rd(3'h0, 8'h5A);
        reg_rd(3'h1, 8'h3C);
        for (int a = 0; a < 4; a++) begin
            u_ctl.start();
            u_ctl.send_byte({7'h74 + 7'(a), 1'b0}, ack);
            u_ctl.stop();
            check({15'h0000, ack}, {15'h0000, a == 2});
        end
        reg_wr(3'h2, 8'hA5);
        reg_wr(3'h6, 8'h0F);
        check({port_oe[7:0], port_drv[7:0]}, 16'hF0A5);
        check({pull_hi[7:0], pull_lo[7:0]}, 16'hA050);
        reg_rd(3'h0, 8'hAA);
        reg_wr(3'h0, 8'h55);
        reg_rd(3'h0, 8'hAA);
        reg_wr(3'h5, 8'hFF);
        reg_rd(3'h1, 8'hC3);
        reg_rd(3'h6, 8'h0F);
        rd_pair(8'hFF, 8'h0F);
        rd_pair(8'hFF, 8'h0F);
        reg_rd(3'h0, 8'hAA);
        reg_rd(3'h1, 8'hC3);
        alert_is(1'b0);
        // bit 4 of port 0 is an output now, so only bit 0 may raise the alert
        pin_ext = 16'h3C4A;
        alert_is(1'b0);
        pin_ext = 16'h3C5B;
        alert_is(1'b1);
        pin_ext = 16'h3C5A;
        alert_is(1'b0);
        pin_ext = 16'h3C4B;
        alert_is(1'b1);
        reg_rd(3'h1, 8'hC3);
        alert_is(1'b1);
        reg_rd(3'h0, 8'hAB);
        alert_is(1'b0);
        ext_rst_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        ext_rst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        check(port_oe, 16'h0000);
        reg_rd(3'h2, 8'hFF);
        wrap_up();
    end
endmodule

`default_nettype wire
